// ### hdl/addressing_channel_activation.sv
// Addressing channel activation, lock and reset handling
`timescale 1ns/10ps
`include "addr_chan_defines.svh"

module addressing_channel_activation #(
    parameter int WIN_CYC  = `WIN_CYC,
    parameter int HOLD_CYC = `HOLD_CYC,
    parameter int MODE_CYC = `MODE_CYC
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_nrst,
    input  wire logic              i_addressing_input,
    input  wire logic              i_init_done,
    input  wire logic              i_slave_mode,
    input  wire logic              i_line_done,
    input  wire logic [`TEL_W-1:0] i_line_data,
    input  wire logic              i_addr_done,
    input  wire logic [`TEL_W-1:0] i_addr_data,
    input  wire logic              i_addr_err,
    input  wire logic [3:0]        i_addr_err_bits,
    input  wire logic              i_reset_call,
    input  wire logic              i_xchg_block,
    input  wire logic              i_wdog_reset,
    input  wire logic              i_pause_det,
    input  wire logic              i_tx_request,
    input  wire logic              i_tx_level,
    input  wire logic [3:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    output logic                   o_addr_active,
    output logic                   o_addr_accept,
    output logic [`TEL_W-1:0]      o_addr_tel,
    output logic                   o_out_reset,
    output logic                   o_data_strobe,
    output logic                   o_param_strobe,
    output logic                   o_clr_xchg_block,
    output logic                   o_init_hold,
    output logic                   o_sync_rx_mode,
    output logic                   o_rx_enable,
    output logic                   o_tx_enable,
    output logic                   o_comp_reinit,
    output logic                   o_voltage_mode,
    output logic                   o_response_output
);

    addr_chan_pkg::chan_state_type state_q;

    logic [31:0]        ctrl_q;
    logic [5:0]         line_age_q;
    logic [`TEL_W-1:0]  line_tel_q;
    logic               pend_q;
    logic [5:0]         pend_age_q;
    logic [`TEL_W-1:0]  pend_tel_q;
    logic               match_now;
    logic               match_late;
    logic               good;
    logic               err_clear;
    logic [2:0]         cnt_q;
    logic [16:0]        win_q;
    logic [14:0]        hold_q;
    logic               in_hold;
    logic               cur_mode;
    logic               locked_cur;
    logic               det_en;
    logic               sel_ctrl;
    logic               sel_status;

    // True when a payload equals one seen within the correlation span
    function automatic logic tel_match(input logic [`TEL_W-1:0] a,
                                       input logic [`TEL_W-1:0] b,
                                       input logic [5:0]        age);
        tel_match = (age <= `MATCH_CYC) && (a == b);
    endfunction : tel_match

    assign in_hold    = (state_q == addr_chan_pkg::ch_hold);
    assign cur_mode   = !o_voltage_mode;
    assign locked_cur = (state_q != addr_chan_pkg::ch_seek) && cur_mode;
    assign det_en     = ctrl_q[`CTRL_DET_EN];

    input_mode_filter #(
        .FILTER_CYC (MODE_CYC)
    ) u_mode (
        .i_core_clk     (i_core_clk),
        .i_nrst         (i_nrst),
        .i_pin          (i_addressing_input),
        .i_init_done    (i_init_done),
        .i_freeze       (o_addr_active),
        .o_voltage_mode (o_voltage_mode)
    );

    // Both paths are decoded side by side; no check on line idle here
    assign match_now  = i_addr_done && !in_hold &&
                        tel_match(line_tel_q, i_addr_data, line_age_q);
    assign match_late = pend_q && i_line_done &&
                        tel_match(i_line_data, pend_tel_q, 6'h0);
    // A telegram counts only once its span has passed without a twin
    assign good       = pend_q && !match_late &&
                        (pend_age_q == `MATCH_CYC);
    assign err_clear  = i_addr_err && (i_addr_err_bits > `ERR_BITS_LO) &&
                        (i_addr_err_bits < `ERR_BITS_HI);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            line_age_q <= 6'h3F;
            line_tel_q <= '0;
        end else if (i_line_done && !in_hold) begin
            line_age_q <= 6'h0;
            line_tel_q <= i_line_data;
        end else if (line_age_q != 6'h3F) begin
            line_age_q <= line_age_q + 6'h1;
        end
    end

    // Waiting slot for a telegram whose twin may still arrive
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pend_q     <= 1'b0;
            pend_age_q <= 6'h0;
            pend_tel_q <= '0;
        end else if (in_hold) begin
            pend_q <= 1'b0;
        end else if (i_addr_done && !match_now) begin
            pend_q     <= 1'b1;
            pend_age_q <= 6'h0;
            pend_tel_q <= i_addr_data;
        end else if (match_late || good) begin
            pend_q <= 1'b0;
        end else if (pend_q) begin
            pend_age_q <= pend_age_q + 6'h1;
        end
    end

    // Activation counter and window
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt_q <= 3'h0;
            win_q <= '0;
        end else if (state_q != addr_chan_pkg::ch_seek) begin
            cnt_q <= 3'h0;
        end else if (match_now || match_late || err_clear || !det_en) begin
            cnt_q <= 3'h0;
        end else if (cnt_q != 3'h0 && win_q >= 17'(WIN_CYC)) begin
            cnt_q <= good ? 3'h1 : 3'h0;
            win_q <= '0;
        end else if (good && i_init_done && i_slave_mode) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h0) begin
                win_q <= '0;
            end
        end else if (cnt_q != 3'h0) begin
            win_q <= win_q + 17'h1;
        end
    end

    // Channel state; only chip reset or the cases below leave it
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= addr_chan_pkg::ch_seek;
            hold_q  <= '0;
        end else begin
            unique case (state_q)
                addr_chan_pkg::ch_seek: begin
                    if (good && det_en && !err_clear && i_init_done &&
                        i_slave_mode && cnt_q == `MAGIC_COUNT - 3'h1 &&
                        !(win_q >= 17'(WIN_CYC))) begin
                        state_q <= addr_chan_pkg::ch_active;
                    end
                end
                addr_chan_pkg::ch_active: begin
                    if (i_reset_call && cur_mode && !i_xchg_block) begin
                        state_q <= addr_chan_pkg::ch_hold;
                        hold_q  <= '0;
                    end else if (i_reset_call) begin
                        state_q <= addr_chan_pkg::ch_seek;
                    end else if (i_wdog_reset && !cur_mode) begin
                        state_q <= addr_chan_pkg::ch_seek;
                    end
                end
                addr_chan_pkg::ch_hold: begin
                    if (hold_q == 15'(HOLD_CYC - 1)) begin
                        state_q <= addr_chan_pkg::ch_active;
                    end else begin
                        hold_q <= hold_q + 15'h1;
                    end
                end
            endcase
        end
    end

    // Output reset and strobes on activation and on a locked reset call in current mode with i_xchg_block low
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_out_reset      <= 1'b0;
            o_data_strobe    <= 1'b0;
            o_param_strobe   <= 1'b0;
            o_clr_xchg_block <= 1'b0;
        end else begin
            o_out_reset      <= 1'b0;
            o_data_strobe    <= 1'b0;
            o_param_strobe   <= 1'b0;
            o_clr_xchg_block <= 1'b0;
            if (state_q == addr_chan_pkg::ch_seek && good && det_en &&
                !err_clear && i_init_done && i_slave_mode &&
                cnt_q == `MAGIC_COUNT - 3'h1 &&
                !(win_q >= 17'(WIN_CYC))) begin
                o_out_reset      <= 1'b1;
                o_data_strobe    <= 1'b1;
                o_param_strobe   <= 1'b1;
                o_clr_xchg_block <= 1'b1;
            end else if (state_q == addr_chan_pkg::ch_active &&
                         i_reset_call && cur_mode && !i_xchg_block) begin
                o_out_reset    <= 1'b1;
                o_data_strobe  <= 1'b1;
                o_param_strobe <= 1'b1;
            end
        end
    end

    // Telegrams reach the slave logic only while locked and not held
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_addr_accept <= 1'b0;
            o_addr_tel    <= '0;
        end else begin
            o_addr_accept <= good &&
                             state_q == addr_chan_pkg::ch_active;
            if (good) begin
                o_addr_tel <= pend_tel_q;
            end
        end
    end

    // Open-drain response pin idles released (high) when not sending
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_addr_active     <= 1'b0;
            o_init_hold       <= 1'b0;
            o_sync_rx_mode    <= 1'b0;
            o_response_output <= 1'b1;
        end else begin
            o_addr_active     <= (state_q != addr_chan_pkg::ch_seek);
            o_init_hold       <= in_hold;
            o_sync_rx_mode    <= locked_cur;
            o_response_output <= !(o_addr_active && i_tx_request) ||
                                 i_tx_level;
        end
    end

    // Transmit request wins; the receiver is off while sending
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_tx_enable   <= 1'b0;
            o_rx_enable   <= 1'b1;
            o_comp_reinit <= 1'b0;
        end else begin
            o_tx_enable   <= i_tx_request;
            o_rx_enable   <= !i_tx_request;
            o_comp_reinit <= i_pause_det;
        end
    end

    // Avalon slave: one wait cycle, then the access completes
    assign sel_ctrl   = (i_avs_address == `REG_CTRL);
    assign sel_status = (i_avs_address == `REG_STATUS);

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata    <= 32'h0000_0000;
            ctrl_q            <= `CTRL_RESET;
        end else if (!o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'b1;
            if (i_avs_write && sel_ctrl && i_avs_byteenable[0]) begin
                ctrl_q <= {31'h0, i_avs_writedata[`CTRL_DET_EN]};
            end
        end else if (i_avs_read || i_avs_write) begin
            o_avs_waitrequest <= 1'b0;
            o_avs_readdata    <= 32'h0000_0000;
            if (i_avs_read && sel_ctrl) begin
                o_avs_readdata <= ctrl_q;
            end else if (i_avs_read && sel_status) begin
                o_avs_readdata[`ST_ACTIVE]               <= o_addr_active;
                o_avs_readdata[`ST_HOLD]                 <= in_hold;
                o_avs_readdata[`ST_VMODE]                <= o_voltage_mode;
                o_avs_readdata[`ST_CNT_LO+2:`ST_CNT_LO]  <= cnt_q;
                o_avs_readdata[`ST_SYNC_RX]              <= o_sync_rx_mode;
            end
        end
    end

endmodule : addressing_channel_activation

// ### hdl/input_mode_filter.sv
// Current/voltage mode filter for the addressing input pin
`timescale 1ns/10ps
`include "addr_chan_defines.svh"

module input_mode_filter #(
    parameter int FILTER_CYC = `MODE_CYC
) (
    input  wire logic i_core_clk,
    input  wire logic i_nrst,
    input  wire logic i_pin,
    input  wire logic i_init_done,
    input  wire logic i_freeze,
    output logic      o_voltage_mode
);

    logic        meta_q;
    logic        sync_q;
    logic        seen_q;
    logic [16:0] cnt_q;

    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_pin;
            sync_q <= meta_q;
        end
    end

    // Starting mode is caught from the pin when initialisation ends
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            seen_q         <= 1'b0;
            cnt_q          <= '0;
            o_voltage_mode <= 1'b0;
        end else if (!seen_q) begin
            if (i_init_done) begin
                seen_q         <= 1'b1;
                o_voltage_mode <= sync_q;
            end
        end else if (i_freeze || sync_q == o_voltage_mode) begin
            cnt_q <= '0;
        end else if (cnt_q == 17'(FILTER_CYC)) begin
            cnt_q          <= '0;
            o_voltage_mode <= sync_q;
        end else begin
            cnt_q <= cnt_q + 17'h1;
        end
    end

endmodule : input_mode_filter

// ### shared/addr_chan_defines.svh
// Timing counts, register offsets and field positions of the channel block
`ifndef ADDR_CHAN_DEFINES_SVH
`define ADDR_CHAN_DEFINES_SVH

`define CLK_PERIOD_NS   100
`define TEL_W           11
`define MAGIC_COUNT     3'h4
`define ERR_BITS_LO     4'h5
`define ERR_BITS_HI     4'hE

// Activation window, nominal length
`define WIN_TIME_NS     8192000
`define WIN_CYC         (`WIN_TIME_NS / `CLK_PERIOD_NS)
// Re-initialisation delay, least time after -6.25 percent tolerance
`define HOLD_TIME_NS    2048000
`define HOLD_MIN_NS     (`HOLD_TIME_NS * 15 / 16)
`define HOLD_CYC        ((`HOLD_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Input mode filter, least time
`define MODE_TIME_NS    7680000
`define MODE_CYC        ((`MODE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Telegram correlation span, longest time
`define MATCH_TIME_NS   3000
`define MATCH_CYC       6'(`MATCH_TIME_NS / `CLK_PERIOD_NS)

`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define CTRL_DET_EN     0
`define CTRL_RESET      32'h0000_0001
`define ST_ACTIVE       0
`define ST_HOLD         1
`define ST_VMODE        2
`define ST_CNT_LO       3
`define ST_SYNC_RX      6

`endif

// ### shared/addr_chan_pkg.sv
// Types shared by the addressing channel block
package addr_chan_pkg;

    typedef enum logic [1:0] {
        ch_seek,
        ch_active,
        ch_hold
    } chan_state_type;

endpackage : addr_chan_pkg

// ### sim/addr_chan_monitor.sv
// Concurrent checks on the ports of the addressing channel block
`timescale 1ns/10ps
module addr_chan_monitor #(
    parameter int HOLD_CYC = 50
) (
    input wire logic i_core_clk,
    input wire logic i_nrst,
    input wire logic i_addr_done,
    input wire logic i_pause_det,
    input wire logic i_tx_request,
    input wire logic i_wdog_reset,
    input wire logic o_avs_waitrequest,
    input wire logic o_addr_active,
    input wire logic o_addr_accept,
    input wire logic o_out_reset,
    input wire logic o_data_strobe,
    input wire logic o_param_strobe,
    input wire logic o_clr_xchg_block,
    input wire logic o_init_hold,
    input wire logic o_sync_rx_mode,
    input wire logic o_rx_enable,
    input wire logic o_tx_enable,
    input wire logic o_comp_reinit,
    input wire logic o_voltage_mode
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_nrst);
    int hold_q;
    always_ff @(posedge i_core_clk or negedge i_nrst) begin
        if (!i_nrst) hold_q <= 0;
        else hold_q <= o_init_hold ? hold_q + 1 : 0;
    end
    rx_tx_excl_a: assert property (!(o_rx_enable && o_tx_enable))
        else $error("receiver and transmitter both on");
    tx_turn_a: assert property (i_tx_request |=> o_tx_enable && !o_rx_enable)
        else $error("transmit request did not swap enables");
    reinit_a: assert property (i_pause_det |=> o_comp_reinit)
        else $error("pause did not reinit comparators");
    strobe_set_a: assert property (o_data_strobe |-> o_param_strobe && o_out_reset)
        else $error("strobes not issued together");
    act_after_a: assert property (o_clr_xchg_block |=> o_addr_active)
        else $error("activation did not follow flag clear");
    accept_src_a: assert property (o_addr_accept |-> o_addr_active && $past(i_addr_done, 32))
        else $error("accept without active channel or telegram");
    hold_quiet_a: assert property (o_init_hold |-> !o_addr_accept)
        else $error("telegram accepted during hold");
    hold_len_a: assert property (o_init_hold |-> hold_q < HOLD_CYC)
        else $error("hold lasted too long");
    sync_cur_a: assert property (o_sync_rx_mode |-> !o_voltage_mode)
        else $error("sync receive outside current mode");
    wdog_keep_a: assert property (o_addr_active && !o_voltage_mode && !o_init_hold && i_wdog_reset |=> o_addr_active)
        else $error("watchdog reset left the channel");
    wait_one_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    cover property (o_clr_xchg_block);
    cover property (o_init_hold && i_addr_done);
    cover property (o_addr_accept);
endmodule : addr_chan_monitor

bind addressing_channel_activation addr_chan_monitor #(
    .HOLD_CYC(HOLD_CYC)
) u_addr_chan_monitor (.*);

// ### sim/addressing_channel_activation_test.sv
// Self-checking bench for the addressing channel activation block
`timescale 1ns/10ps
`include "addr_chan_defines.svh"
`define CHK(n, e, g) chk(n, 32'(e), 32'(g))
module addressing_channel_activation_test;
    localparam int WIN = 200;
    localparam int HOLD = 50;
    localparam int MODE = 40;
    logic i_core_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_addressing_input, i_addr_done, i_addr_err, i_init_done;
    logic [`TEL_W-1:0] i_addr_data, i_line_data, o_addr_tel, d;
    logic [3:0] i_addr_err_bits, i_avs_address, i_avs_byteenable;
    logic [31:0] i_avs_writedata, o_avs_readdata, rd;
    logic i_slave_mode, i_line_done, i_reset_call, i_xchg_block;
    logic i_wdog_reset, i_pause_det, i_tx_request, i_tx_level;
    logic i_avs_read, i_avs_write, o_avs_waitrequest, o_addr_active;
    logic o_addr_accept, o_out_reset, o_data_strobe, o_param_strobe;
    logic o_clr_xchg_block, o_init_hold, o_sync_rx_mode, o_rx_enable;
    logic o_tx_enable, o_comp_reinit, o_voltage_mode, o_response_output;
    logic lvl;
    bit ok;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int hold_n = 0;
    int acc_n = 0;
    int exp_cnt, h0, a0;
    logic [`TEL_W-1:0] exp_q[$];
    wire logic [3:0] ev = {o_init_hold, o_addr_active, o_data_strobe,
                           o_addr_accept};

    addressing_channel_activation #(
        .WIN_CYC (WIN),
        .HOLD_CYC(HOLD),
        .MODE_CYC(MODE)
    ) u_addressing_channel_activation (.*);
    handheld_model u_handheld_model (
        .i_core_clk(i_core_clk),
        .o_pin     (i_addressing_input),
        .o_done    (i_addr_done),
        .o_data    (i_addr_data),
        .o_err     (i_addr_err),
        .o_err_bits(i_addr_err_bits)
    );

    always #50 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        cyc++;
        hold_n += (o_init_hold === 1'b1);
        acc_n += (o_addr_accept === 1'b1);
        if (cyc == 20000) begin
            error_cnt++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    // Waits on waitrequest, never on a fixed latency
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge i_core_clk);
        i_avs_address <= a;
        i_avs_read <= !wr;
        i_avs_write <= wr;
        i_avs_writedata <= wd;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_avs_waitrequest !== 1'b0 && k < 100);
        rd = o_avs_readdata;
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        if (k >= 100) `CHK("bus answer", 0, 1);
    endtask : bus
    task automatic wt(input int s, input int lim);
        ok = 1'b0;
        repeat (lim) begin
            @(posedge i_core_clk);
            #1;
            if (ev[s] === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
    endtask : wt
    // Telegram, optionally followed by payload lx on the main line after lag cycles
    task automatic tel(input logic [`TEL_W-1:0] x, input int lag,
                       input logic [`TEL_W-1:0] lx);
        u_handheld_model.send(x);
        if (lag > 0) begin
            repeat (lag) @(posedge i_core_clk);
            i_line_done <= 1'b1;
            i_line_data <= lx;
            @(posedge i_core_clk);
            i_line_done <= 1'b0;
            i_line_data <= ~lx;
        end
        repeat (36 - lag) @(posedge i_core_clk);
    endtask : tel
    task automatic cnt_chk();
        bus(1'b0, `REG_STATUS, 32'h0);
        `CHK("count", exp_cnt, rd[`ST_CNT_LO +: 3]);
    endtask : cnt_chk
    task automatic pulse_reset_call();
        @(posedge i_core_clk);
        i_reset_call <= 1'b1;
        @(posedge i_core_clk);
        i_reset_call <= 1'b0;
    endtask : pulse_reset_call
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    initial begin
        void'($urandom(32'hFACDD433));
        {i_init_done, i_slave_mode, i_line_done, i_reset_call} = '0;
        {i_xchg_block, i_wdog_reset, i_pause_det, i_tx_request} = '0;
        {i_tx_level, i_avs_read, i_avs_write, i_line_data} = '0;
        {i_avs_address, i_avs_writedata} = '0;
        i_avs_byteenable = 4'hF;
        repeat (16) @(posedge i_core_clk);
        i_nrst <= 1'b1;
        i_init_done <= 1'b1;
        i_slave_mode <= 1'b1;
        bus(1'b0, `REG_CTRL, 32'h0);
        `CHK("ctrl reset", 32'h1, rd);
        bus(1'b0, `REG_STATUS, 32'h0);
        `CHK("status reset", 32'h0, rd);
        bus(1'b1, 4'h8, 32'hFFFFFFFF);
        bus(1'b0, 4'h8, 32'h0);
        `CHK("unmapped", 32'h0, rd);
        bus(1'b1, `REG_CTRL, 32'h0);
        bus(1'b0, `REG_CTRL, 32'h0);
        `CHK("ctrl write", 32'h0, rd);
        bus(1'b1, `REG_CTRL, `CTRL_RESET);
        $display("test registers done");
        // Error bit counts either side of both clearing limits
        exp_cnt = 0;
        for (int b = 4; b < 16; b++) begin
            tel(11'($urandom), 0, '0);
            u_handheld_model.fail(4'(b));
            repeat (3) @(posedge i_core_clk);
            exp_cnt = (b > 5 && b < 14) ? 0 : exp_cnt + 1;
            cnt_chk();
        end
        repeat (WIN + 20) @(posedge i_core_clk);
        exp_cnt = 0;
        cnt_chk();
        $display("test errors done");
        d = 11'($urandom);
        tel(d, 0, '0);
        tel(d, 8, d);
        cnt_chk();
        // Main line first, then the same payload on the addressing input
        tel(d, 0, '0);
        @(posedge i_core_clk);
        i_line_done <= 1'b1;
        i_line_data <= d;
        @(posedge i_core_clk);
        i_line_done <= 1'b0;
        tel(d, 0, '0);
        cnt_chk();
        $display("test twin done");
        // Main line busy with other payloads while the sequence arrives
        for (int i = 0; i < 3; i++) begin
            d = 11'($urandom);
            tel(d, 5, ~d);
        end
        u_handheld_model.send(11'($urandom));
        wt(1, 40);
        `CHK("strobes", 3'b111, {o_clr_xchg_block, o_param_strobe, o_out_reset});
        wt(2, 5);
        `CHK("active", 1, ok);
        #100;
        `CHK("sync rx", 1, o_sync_rx_mode);
        d = 11'($urandom);
        exp_q.push_back(d);
        u_handheld_model.send(d);
        wt(0, 40);
        `CHK("accept", 1, ok);
        `CHK("tel", exp_q.pop_front(), o_addr_tel);
        i_tx_request <= 1'b1;
        repeat (8) begin
            @(posedge i_core_clk);
            lvl = 1'($urandom);
            i_tx_level <= lvl;
            i_pause_det <= lvl;
            @(posedge i_core_clk);
            #1;
            `CHK("response", lvl, o_response_output);
            `CHK("reinit", lvl, o_comp_reinit);
            `CHK("tx on", 2'b01, {o_rx_enable, o_tx_enable});
        end
        i_tx_request <= 1'b0;
        i_pause_det <= 1'b0;
        u_handheld_model.level(1'b1);
        repeat (MODE + 10) @(posedge i_core_clk);
        `CHK("mode lock", 0, o_voltage_mode);
        u_handheld_model.level(1'b0);
        $display("test activation done");
        @(posedge i_core_clk);
        i_wdog_reset <= 1'b1;
        @(posedge i_core_clk);
        i_wdog_reset <= 1'b0;
        repeat (3) @(posedge i_core_clk);
        `CHK("wdog keep", 1, o_addr_active);
        h0 = hold_n;
        a0 = acc_n;
        pulse_reset_call();
        // Strobes stand for the one cycle right after the call is taken
        #1;
        `CHK("reset strobes", 7, {o_out_reset, o_data_strobe, o_param_strobe});
        u_handheld_model.send(11'($urandom));
        for (int k = 0; k < HOLD + 20 && o_init_hold !== 1'b0; k++)
            @(posedge i_core_clk);
        repeat (40) @(posedge i_core_clk);
        `CHK("hold length", HOLD, hold_n - h0);
        `CHK("hold accepts", 0, acc_n - a0);
        `CHK("kept active", 1, o_addr_active);
        $display("test reset call done");
        i_xchg_block <= 1'b1;
        pulse_reset_call();
        repeat (HOLD + 10) @(posedge i_core_clk);
        `CHK("left channel", 0, o_addr_active);
        u_handheld_model.level(1'b1);
        repeat (MODE + 10) @(posedge i_core_clk);
        `CHK("voltage mode", 1, o_voltage_mode);
        u_handheld_model.level(1'b0);
        repeat (MODE + 10) @(posedge i_core_clk);
        `CHK("current mode", 0, o_voltage_mode);
        $display("test mode done");
        final_report();
    end
endmodule : addressing_channel_activation_test

// ### sim/handheld_model.sv
// Handheld programmer model feeding the addressing input receiver side
`timescale 1ns/10ps
`include "addr_chan_defines.svh"
module handheld_model (
    input  wire logic          i_core_clk,
    output logic               o_pin,
    output logic               o_done,
    output logic [`TEL_W-1:0]  o_data,
    output logic               o_err,
    output logic [3:0]         o_err_bits
);
    initial begin
        {o_pin, o_done, o_err, o_err_bits, o_data} = '0;
    end
    // One good telegram; payload is not held once the pulse is over
    task automatic send(input logic [`TEL_W-1:0] d);
        @(posedge i_core_clk);
        o_done <= 1'b1;
        o_data <= d;
        @(posedge i_core_clk);
        o_done <= 1'b0;
        o_data <= ~d;
    endtask : send
    task automatic fail(input logic [3:0] n);
        @(posedge i_core_clk);
        o_err <= 1'b1;
        o_err_bits <= n;
        @(posedge i_core_clk);
        o_err <= 1'b0;
        o_err_bits <= ~n;
    endtask : fail
    task automatic level(input logic v);
        @(posedge i_core_clk);
        o_pin <= v;
    endtask : level
endmodule : handheld_model
